// file: design/bridge_command.sv
// command register of a bridge port with its decode, forwarding and error gating
// What this block does
// RULE1: io decode enable low ignores i/o window hits; high claims them
// RULE2: mem decode enable low blocks memory and prefetchable window claims
// RULE3: master enable low blocks upstream memory and i/o requests as unsupported; message and completion requests still pass
// RULE4: master enable low answers upstream non-posted requests with unsupported-request completions
// RULE5: master enable never affects completions or other request kinds
// RULE6: poison response enable gates logging of poisoned tlps in master poison flag
// RULE7: report fatal/non-fatal errors when system error enable or device-control enables set
// RULE8: forward secondary fatal/non-fatal messages only while system error enable set
// RULE9: correctable error messages always forwarded upstream
// RULE10: legacy irq disable deasserts own intx and updates resolved state
// RULE11: legacy irq disable never blocks forwarded secondary intx
// RULE12: bits 3,4,5,7,9 and 15:11 read zero and are read-only
// RULE13: poison flag set on poisoned downstream completion or forwarded upstream request when enabled
// RULE14: signaled system error flag set when sending error message with system error enable
// RULE15: 16-bit register; writes to read-only bits discarded
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "bridge_command_regs.svh"
module bridge_command
(
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [11:0]                  paddr,
    input  wire logic [31:0]                  pwdata,
    input  wire logic [3:0]                   pstrb,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    output logic                              irq,
    input  wire logic                         io_window_hit,
    input  wire logic                         mem_window_hit,
    input  wire logic                         pref_window_hit,
    output logic                              io_claim,
    output logic                              mem_claim,
    input  wire logic                         up_req_valid,
    input  wire bridge_command_pkg::req_kind_t up_req_kind,
    input  wire logic                         up_req_non_posted,
    input  wire logic                         up_req_poisoned,
    output logic                              up_req_forward,
    output logic                              up_req_unsupported,
    output logic                              up_ur_completion,
    input  wire logic                         down_cpl_valid,
    input  wire logic                         down_cpl_poisoned,
    input  wire logic                         err_detected_nonfatal,
    input  wire logic                         err_detected_fatal,
    input  wire logic                         dev_ctl_nonfatal_en,
    input  wire logic                         dev_ctl_fatal_en,
    output logic                              err_send_nonfatal,
    output logic                              err_send_fatal,
    input  wire logic                         sec_msg_nonfatal,
    input  wire logic                         sec_msg_fatal,
    input  wire logic                         sec_msg_corr,
    output logic                              fwd_msg_nonfatal,
    output logic                              fwd_msg_fatal,
    output logic                              fwd_msg_corr,
    input  wire logic                         own_intx_pending,
    input  wire logic                         sec_intx,
    output logic                              own_intx,
    output logic                              resolved_intx,
    output logic                              io_decode_enable,
    output logic                              mem_decode_enable,
    output logic                              upstream_master_enable,
    output logic                              poison_response_enable,
    output logic                              system_error_enable,
    output logic                              legacy_irq_disable
);
    import bridge_command_pkg::*;

    cmd_word_t bridge_command;
    irq_bits_t irq_mask;
    irq_bits_t irq_flags;
    logic [1:0] status_flags;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        return a[11:2] == off[11:2];
    endfunction

    wire logic wr_en;
    wire logic rd_en;
    wire logic sel_cmd;
    wire logic sel_sts;
    wire logic sel_irq;
    wire logic sel_msk;
    wire logic mapped;
    assign wr_en   = psel & penable & pwrite;
    assign rd_en   = psel & penable & ~pwrite;
    assign sel_cmd = hit(paddr, `CMD_OFFSET);
    assign sel_sts = hit(paddr, `STATUS_OFFSET);
    assign sel_irq = hit(paddr, `IRQ_STATUS_OFFSET);
    assign sel_msk = hit(paddr, `IRQ_MASK_OFFSET);
    assign mapped  = sel_cmd | sel_sts | sel_irq | sel_msk;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // byte-lane merge, read-only bits kept zero
    wire logic [15:0] lane_mask;
    wire cmd_word_t   next_bridge_command;
    assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    assign next_bridge_command = (bridge_command & ~(lane_mask & `CMD_WRITE_MASK))
                               | (pwdata[15:0] & lane_mask & `CMD_WRITE_MASK); // RULE12 RULE15

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            bridge_command <= `CMD_RESET;
        else if (wr_en && sel_cmd)
            bridge_command <= next_bridge_command;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_mask <= `IRQ_RESET;
        else if (wr_en && sel_msk && pstrb[0])
            irq_mask <= pwdata[`IRQ_WIDTH-1:0];
    end

    assign io_decode_enable       = bridge_command[`BIT_IO_EN];
    assign mem_decode_enable      = bridge_command[`BIT_MEM_EN];
    assign upstream_master_enable = bridge_command[`BIT_MASTER_EN];
    assign poison_response_enable = bridge_command[`BIT_POISON_EN];
    assign system_error_enable    = bridge_command[`BIT_SERR_EN];
    assign legacy_irq_disable     = bridge_command[`BIT_IRQ_DIS];

    // primary-side decode
    assign io_claim  = io_window_hit & io_decode_enable; // RULE1
    assign mem_claim = (mem_window_hit | pref_window_hit) & mem_decode_enable; // RULE2

    // upstream request gating
    wire logic gated_kind;
    wire logic blocked;
    assign gated_kind         = (up_req_kind == req_mem) | (up_req_kind == req_io); // RULE5
    assign blocked            = up_req_valid & gated_kind & ~upstream_master_enable; // RULE3
    assign up_req_forward     = up_req_valid & ~blocked; // RULE5
    assign up_req_unsupported = blocked; // RULE3
    assign up_ur_completion   = blocked & up_req_non_posted; // RULE4

    // error reporting and message forwarding
    assign err_send_nonfatal = err_detected_nonfatal & (system_error_enable | dev_ctl_nonfatal_en); // RULE7
    assign err_send_fatal    = err_detected_fatal & (system_error_enable | dev_ctl_fatal_en); // RULE7
    assign fwd_msg_nonfatal  = sec_msg_nonfatal & system_error_enable; // RULE8
    assign fwd_msg_fatal     = sec_msg_fatal & system_error_enable; // RULE8
    assign fwd_msg_corr      = sec_msg_corr; // RULE9

    // legacy interrupts
    assign own_intx      = own_intx_pending & ~legacy_irq_disable; // RULE10
    assign resolved_intx = own_intx | sec_intx; // RULE11

    // status flags
    wire logic poison_event;
    wire logic serr_event;
    wire logic [1:0] status_set;
    wire logic [1:0] status_clr;
    assign poison_event = poison_response_enable
                        & ((down_cpl_valid & down_cpl_poisoned)
                        | (up_req_forward & up_req_poisoned)); // RULE6 RULE13
    assign serr_event   = system_error_enable & (err_send_nonfatal | err_send_fatal); // RULE14
    assign status_set   = {serr_event, poison_event};
    assign status_clr   = (wr_en && sel_sts && pstrb[0]) ? pwdata[1:0] : 2'b00;

    sticky_bits #(.WIDTH(2)) status_regs
    (
        .pclk       (pclk),
        .presetn    (presetn),
        .set_bits   (status_set),
        .clear_bits (status_clr),
        .flags      (status_flags)
    );

    // interrupt events
    wire irq_bits_t irq_set;
    wire irq_bits_t irq_clr;
    assign irq_set = {blocked, blocked, serr_event, poison_event};
    assign irq_clr = (wr_en && sel_irq && pstrb[0]) ? pwdata[`IRQ_WIDTH-1:0] : `IRQ_RESET;

    sticky_bits #(.WIDTH(`IRQ_WIDTH)) irq_regs
    (
        .pclk       (pclk),
        .presetn    (presetn),
        .set_bits   (irq_set),
        .clear_bits (irq_clr),
        .flags      (irq_flags)
    );
    assign irq = |(irq_flags & irq_mask);

    // read data
    wire logic [31:0] rd_mux;
    assign rd_mux = sel_cmd ? {16'h0000, bridge_command}
                  : sel_sts ? {30'h0000_0000, status_flags}
                  : sel_irq ? {28'h000_0000, irq_flags}
                  : sel_msk ? {28'h000_0000, irq_mask}
                  : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
            prdata <= rd_mux;
    end
endmodule // bridge_command
`default_nettype wire

// file: design/bridge_command_regs.svh
// offsets, field positions, reset values and layouts of the bridge command block
`ifndef BRIDGE_COMMAND_REGS_SVH
`define BRIDGE_COMMAND_REGS_SVH
`define CMD_OFFSET        12'h004
`define STATUS_OFFSET     12'h008
`define IRQ_STATUS_OFFSET 12'h00C
`define IRQ_MASK_OFFSET   12'h010
`define CMD_RESET         16'h0000
`define CMD_WRITE_MASK    16'h0547
`define BIT_IO_EN         0
`define BIT_MEM_EN        1
`define BIT_MASTER_EN     2
`define BIT_POISON_EN     6
`define BIT_SERR_EN       8
`define BIT_IRQ_DIS       10
`define STS_POISON        0
`define STS_SERR          1
`define IRQ_WIDTH         4
`define IRQ_RESET         4'h0
`define IRQ_POISON        0
`define IRQ_SERR          1
`define IRQ_UR            2
`define IRQ_FWD_BLOCKED   3
`endif

// file: design/bridge_command_pkg.sv
// types shared by the bridge command block
package bridge_command_pkg;
    typedef logic [15:0] cmd_word_t;
    typedef logic [3:0]  irq_bits_t;
    typedef enum logic [1:0]
    {
        req_mem = 2'b00,
        req_io  = 2'b01,
        req_msg = 2'b10,
        req_cpl = 2'b11
    } req_kind_t;
endpackage

// file: design/sticky_bits.sv
// sticky write-one-to-clear flags, set winning over clear
`timescale 1ns/1ps
`default_nettype none
module sticky_bits
#(
    parameter int WIDTH = 4
)
(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] set_bits,
    input  wire logic [WIDTH-1:0] clear_bits,
    output var  logic [WIDTH-1:0] flags
);
    wire logic [WIDTH-1:0] next_flags;
    assign next_flags = set_bits | (flags & ~clear_bits);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flags <= '0;
        else
            flags <= next_flags;
    end
endmodule // sticky_bits
`default_nettype wire

// file: tb/cmd_chk.sv
// port checker for the bridge command block
`timescale 1ns/1ps
`default_nettype none
module cmd_chk
(
    input wire logic pclk, presetn, psel, penable, pwrite, io_window_hit, mem_window_hit, pref_window_hit,
    input wire logic [11:0] paddr,
    input wire logic io_claim, mem_claim, up_req_valid, up_req_forward, up_req_unsupported,
    input wire bridge_command_pkg::req_kind_t up_req_kind,
    input wire logic err_detected_fatal, dev_ctl_fatal_en, err_send_fatal, sec_msg_nonfatal, fwd_msg_nonfatal,
    input wire logic own_intx_pending, own_intx, io_decode_enable, mem_decode_enable, upstream_master_enable,
    input wire logic poison_response_enable, system_error_enable, legacy_irq_disable
);
    import bridge_command_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_io_claim: assert property (io_claim == (io_window_hit && io_decode_enable)) else $error("io claim");
    a_mem_claim_off: assert property ((mem_window_hit || pref_window_hit) && !mem_decode_enable |-> !mem_claim)
        else $error("mem claim");
    a_up_blocked: assert property (up_req_valid && !up_req_kind[1] && !upstream_master_enable
        |-> up_req_unsupported && !up_req_forward) else $error("up block");
    a_other_passes: assert property (up_req_valid && up_req_kind[1] |-> up_req_forward)
        else $error("other kind");
    a_err_report: assert property (err_send_fatal == (err_detected_fatal && (system_error_enable || dev_ctl_fatal_en)))
        else $error("err send");
    a_msg_gate: assert property (fwd_msg_nonfatal == (sec_msg_nonfatal && system_error_enable))
        else $error("msg fwd");
    a_own_intx: assert property (own_intx == (own_intx_pending && !legacy_irq_disable)) else $error("intx");
    a_bits_hold: assert property ($changed({io_decode_enable, mem_decode_enable, upstream_master_enable,
        poison_response_enable, system_error_enable, legacy_irq_disable})
        |-> $past(psel && penable && pwrite && paddr == 12'h004)) else $error("bits moved");
endmodule // cmd_chk
bind bridge_command cmd_chk u_chk (.*);
`default_nettype wire

// file: tb/far_side.sv
// far-side model: subordinate requests, secondary messages and interrupts
`timescale 1ns/1ps
`default_nettype none
module far_side
(
    input  wire logic [8:0]                stim,
    output logic                           up_req_valid, up_req_non_posted, up_req_poisoned,
    output bridge_command_pkg::req_kind_t  up_req_kind,
    output logic                           sec_msg_nonfatal, sec_msg_fatal, sec_msg_corr, sec_intx
);
    import bridge_command_pkg::*;
    assign up_req_kind = req_kind_t'(stim[7:6]);
    assign {up_req_valid, up_req_non_posted, up_req_poisoned} = {stim[8], stim[5:4]};
    assign {sec_msg_nonfatal, sec_msg_fatal, sec_msg_corr, sec_intx} = stim[3:0];
endmodule // far_side
`default_nettype wire

// file: tb/tb.sv
// self-checking bench for the bridge command block
`timescale 1ns/1ps
`default_nettype none
`include "bridge_command_regs.svh"
module tb;
    import bridge_command_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err, own_intx_pending = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd;
    logic [3:0] pstrb = 4'hf;
    logic io_window_hit = 0, mem_window_hit = 0, pref_window_hit = 0, down_cpl_valid = 0, down_cpl_poisoned = 0;
    logic err_detected_nonfatal = 0, err_detected_fatal = 0, dev_ctl_nonfatal_en = 0, dev_ctl_fatal_en = 0;
    logic [8:0] stim = 0;
    int failures = 0, checked = 0;
    wire logic [31:0] prdata;
    wire req_kind_t up_req_kind;
    wire logic pready, pslverr, irq, io_claim, mem_claim, up_req_valid, up_req_non_posted, up_req_poisoned;
    wire logic up_req_forward, up_req_unsupported, up_ur_completion, err_send_nonfatal, err_send_fatal, sec_intx;
    wire logic sec_msg_nonfatal, sec_msg_fatal, sec_msg_corr, fwd_msg_nonfatal, fwd_msg_fatal, fwd_msg_corr;
    wire logic own_intx, resolved_intx, io_decode_enable, mem_decode_enable, upstream_master_enable;
    wire logic poison_response_enable, system_error_enable, legacy_irq_disable;
    bridge_command DUT (.*);
    far_side u_far (.*);
    always #5 pclk = ~pclk;
    task automatic ck(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk) penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic report_and_stop;
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        #200000 failures++;
        report_and_stop;
    end
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1;
        bus(0, `CMD_OFFSET, 0);
        ck(rd, 0);
        bus(1, `CMD_OFFSET, 32'hffff_ffff);
        bus(0, `CMD_OFFSET, 0);
        ck(rd, 32'h0000_0547);
        @(posedge pclk) {io_window_hit, mem_window_hit, pref_window_hit, own_intx_pending, stim} <= 13'h1_f7f;
        #1 ck({io_claim, mem_claim, up_req_forward, own_intx, fwd_msg_fatal, fwd_msg_corr}, 6'b11_1011);
        bus(1, `CMD_OFFSET, 0);
        @(posedge pclk) mem_window_hit <= 0;
        #1 ck({io_claim, mem_claim, up_req_unsupported, up_ur_completion, own_intx, resolved_intx, fwd_msg_fatal,
            fwd_msg_corr}, 8'b0011_1101);
        for (int k = 0; k < 4; k++)
        begin
            @(posedge pclk) stim <= {1'b1, 2'(k), 6'b10_0000};
            #1 ck({up_req_forward, up_req_unsupported}, k > 1 ? 2'b10 : 2'b01);
        end
        bus(1, `CMD_OFFSET, 32'h0000_0400);
        @(posedge pclk) stim <= 9'h001;
        #1 ck({own_intx, resolved_intx}, 2'b01);
        bus(1, `CMD_OFFSET, 0);
        @(posedge pclk) {err_detected_nonfatal, err_detected_fatal, dev_ctl_nonfatal_en, dev_ctl_fatal_en} <= 4'hf;
        #1 ck({err_send_nonfatal, err_send_fatal}, 2'b11);
        @(posedge pclk) {dev_ctl_nonfatal_en, dev_ctl_fatal_en} <= 2'b00;
        #1 ck({err_send_nonfatal, err_send_fatal}, 2'b00);
        bus(1, `STATUS_OFFSET, 32'h0000_0003);
        bus(1, `IRQ_STATUS_OFFSET, 32'h0000_000f);
        bus(1, `CMD_OFFSET, 32'h0000_0140);
        @(posedge pclk) {down_cpl_valid, down_cpl_poisoned, err_detected_nonfatal, err_detected_fatal} <= 4'hc;
        @(posedge pclk) {down_cpl_valid, down_cpl_poisoned} <= 2'b00;
        #1 ck(irq, 0);
        bus(1, `IRQ_MASK_OFFSET, 32'h0000_0003);
        #1 ck(irq, 1);
        bus(0, `STATUS_OFFSET, 0);
        ck(rd, 32'h0000_0003);
        bus(1, `STATUS_OFFSET, 32'h0000_0003);
        bus(1, `IRQ_STATUS_OFFSET, 32'h0000_000f);
        bus(0, `STATUS_OFFSET, 0);
        ck(rd, 0);
        ck(irq, 0);
        bus(1, 12'h0f0, 32'hffff_ffff);
        ck(err, 1);
        report_and_stop;
    end
endmodule // tb
`default_nettype wire
